// ===== bench/dlt_host.sv
`timescale 1ns/10ps
`default_nettype none
// host side: one avalon master, one transfer at a time
module dlt_host (
  input  wire logic          mclk,
  input  wire logic          avs_waitrequest,
  input  wire logic [31:0]   avs_readdata,
  output var dlt_pkg::dlt_req_s avs_req
);
  import dlt_pkg::*;
  initial avs_req = '0;
  // request held until the edge that sees waitrequest low
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_req <= '{read: !w, write: w, address: a, writedata: d};
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_req <= '0;
  endtask : xfer
endmodule : dlt_host
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dlt_pkg::*;
  localparam int TICK = 10; // short ms prescaler keeps pulses brief
  logic        mclk, resetn, reading_valid, master_limit, irq;
  logic        avs_waitrequest;
  logic [32:0] reading;
  logic [31:0] avs_readdata, q, v;
  logic [3:0]  limit_lines;
  dlt_req_s    avs_req;
  int          errors = 0;
  int          n_compared = 0;
  dlt_top #(.TICK_CYC(TICK)) uut (.mclk(mclk), .resetn(resetn),
    .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reading(reading),
    .reading_valid(reading_valid), .limit_lines(limit_lines),
    .master_limit(master_limit), .irq(irq));
  dlt_host host (.mclk(mclk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_req(avs_req));
  // clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // expected lines: inactive level when outputs are off
  function automatic logic [31:0] lines_exp(input logic [3:0] ev,
                                            input logic en, input logic lo);
    return {28'h0, en ? ev ^ {4{lo}} : {4{lo}}};
  endfunction : lines_exp
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    host.xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rc
  // one reading pulse, then wait until lines have settled
  task automatic meas(input logic [32:0] r);
    @(posedge mclk);
    reading       <= r;
    reading_valid <= 1'b1;
    @(posedge mclk);
    reading_valid <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : meas
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // watchdog well above the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    finish_test;
  end
  initial begin
    void'($urandom(32'h3af8b696));
    resetn = 1'b0;
    reading = 33'h0;
    reading_valid = 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    rc(OFS_CTRL, 32'h000000C0, "ctrl");
    rc(OFS_PW, 32'h00000002, "pw");
    rc(8'h08, 32'h00000001, "upper1");
    rc(8'h18, 32'h00000002, "upper2");
    rc(8'h10, 32'hFFFFFFFF, "lower1");
    rc(8'h14, 32'h00000001, "lower1 sign");
    rc(8'h20, 32'hFFFFFFFE, "lower2");
    wr(8'h3C, 32'hFFFFFFFF);
    rc(8'h3C, 32'h00000000, "unmapped");
    wr(OFS_PW, 32'h00000000);
    rc(OFS_PW, 32'h00000001, "pw min");
    wr(OFS_PW, 32'h05F5E100);
    rc(OFS_PW, 32'h05F5E0FF, "pw max");
    // short width, so earlier pulses are over before the pulse test
    wr(OFS_PW, 32'h00000001);
    v = $urandom_range(1000, 10);
    wr(8'h18, v);
    wr(8'h1C, 32'h00000000);
    rc(8'h18, v, "upper2 rw");
    // test1 on with auto-clear, test2 off
    wr(OFS_CTRL, 32'h000000D2);
    rc(OFS_CTRL, 32'h000000D2, "ctrl rw");
    wr(OFS_MASK, 32'h00000001);
    meas(33'($urandom_range(2000, 1001)));
    chk("lines hi", lines_exp(4'h1, 1'b1, 1'b0), 32'(limit_lines));
    rc(OFS_STAT, 32'h00000001, "stat hi1");
    rc(OFS_RES, 32'h0000000D, "result");
    chk("irq on", 32'h1, 32'(irq));
    wr(OFS_MASK, 32'h00000000);
    @(posedge mclk); // mask lands at the edge the write ends
    chk("irq masked", 32'h0, 32'(irq));
    meas(33'h000000000);
    rc(OFS_STAT, 32'h00000000, "auto clear");
    rc(OFS_RES, 32'h00000000, "pass");
    // auto-clear off: both events accumulate
    wr(OFS_CTRL, 32'h00000012);
    meas(33'h000000005);
    meas(33'h1FFFFFFFB);
    rc(OFS_STAT, 32'h00000003, "stat both");
    wr(OFS_STAT, 32'h00000002);
    rc(OFS_STAT, 32'h00000001, "w1c");
    wr(OFS_CMD, 32'h00000001);
    rc(OFS_STAT, 32'h00000000, "clear1");
    // master_latch_enable master survives the clear
    wr(OFS_CTRL, 32'h00000013);
    meas(33'h000000007);
    wr(OFS_CMD, 32'h00000001);
    rc(OFS_RES, 32'h00000004, "master_latch_enable");
    chk("master", 32'h1, 32'(master_limit));
    wr(OFS_CTRL, 32'h0000001A);
    repeat (2) @(posedge mclk); // ctrl lands as the write ends, the line register one edge later
    chk("lines low", lines_exp(4'h0, 1'b1, 1'b1), 32'(limit_lines));
    // pulsed: active for 1 to 2 ms then back, event stays
    wr(OFS_PW, 32'h00000001);
    wr(OFS_CTRL, 32'h00000016);
    meas(33'h000000009);
    chk("pulse on", lines_exp(4'h1, 1'b1, 1'b0), 32'(limit_lines));
    repeat (3 * TICK) @(posedge mclk);
    chk("pulse off", 32'h0, 32'(limit_lines));
    rc(OFS_STAT, 32'h00000001, "event kept");
    // clear test1 with the preset: kept events would re-raise master
    wr(OFS_CMD, 32'h00000005);
    rc(OFS_CTRL, 32'h000000C0, "preset ctrl");
    rc(OFS_PW, 32'h00000002, "preset pw");
    rc(8'h18, 32'h00000002, "preset upper2");
    chk("preset master", 32'h0, 32'(master_limit));
    // test2 alone: low event, fail flag, immediate clear
    wr(OFS_CTRL, 32'h00000020);
    meas(33'h1FFFFFFFD);
    rc(OFS_STAT, 32'h00000008, "stat lo2");
    rc(OFS_RES, 32'h00000006, "fail2");
    wr(OFS_CMD, 32'h00000002);
    rc(OFS_STAT, 32'h00000000, "clear2");
    finish_test;
  end
endmodule : tb
`default_nettype wire

// ===== verilog/dlt_pkg.sv
`default_nettype none
package dlt_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS       = 1_000_000; // pulse width unit, 1 ms
  // pulse width in ms
  localparam logic [26:0] PW_MIN = 27'h0000001;
  localparam logic [26:0] PW_MAX = 27'h5F5E0FF; // 99999.999 s
  localparam logic [26:0] PW_RST = 27'h0000002;
  // thresholds, 33-bit signed
  localparam logic signed [32:0] THR_MIN = 33'h100000001;
  localparam logic signed [32:0] THR_BAD = 33'h100000000;
  localparam logic [3:0][32:0]   THR_RST = {33'h1FFFFFFFE, 33'h000000002,
                                            33'h1FFFFFFFF, 33'h000000001};
  // byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PW   = 8'h04;
  localparam logic [7:0] OFS_THR  = 8'h08; // 4 x (low word, sign word)
  localparam logic [7:0] OFS_STAT = 8'h28;
  localparam logic [7:0] OFS_MASK = 8'h2C;
  localparam logic [7:0] OFS_CMD  = 8'h30;
  localparam logic [7:0] OFS_RES  = 8'h34;
  // command bits
  localparam int CMD_CLR1   = 0;
  localparam int CMD_CLR2   = 1;
  localparam int CMD_PRESET = 2;
  // control register layout, bit 7 first
  typedef struct packed {
    logic [1:0] auto_clr;     // bits 7:6
    logic [1:0] test_en;      // bits 5:4
    logic       active_low;   // bit 3, output_polarity
    logic       pulse_en;     // bit 2
    logic       outputs_en;   // bit 1
    logic       master_latch; // bit 0, master_latch_enable
  } dlt_cfg_s;
  localparam dlt_cfg_s CFG_RST = 8'hC0;
  // avalon slave request
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
  } dlt_req_s;
  // bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK  = 2'h1
  } dlt_bus_e;
endpackage : dlt_pkg
`default_nettype wire

// ===== verilog/dlt_top.sv
// Notes on behaviour
// - master limit latch is switchable, off after reset
// - global limit output enable, default off, readable
// - pulsed output mode, default off, readable
// - pulse width 1 ms to 99999.999 s, default 2 ms
// - one polarity for all lines, active high default
// - upper thresholds signed within 4294967295, defaults 1 and 2
// - lower thresholds same range, defaults -1 and -2
// - per-test enable, default off, readable
// - per-test fail flag reads 1 while failing
// - immediate clear resets high and low events of a test
// - per-test auto-clear, default on, readable
// - boolean settings: 1 enables, 0 disables
// - reset and preset both load ctrl, width and threshold defaults; only reset clears mask and events
`timescale 1ns/10ps
`default_nettype none
module dlt_top #(
  parameter int TICK_CYC = dlt_pkg::TICK_NS / dlt_pkg::CLK_PERIOD_NS
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire dlt_pkg::dlt_req_s avs_req,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic [32:0]      reading,
  input  wire logic             reading_valid,
  output logic [3:0]            limit_lines,
  output logic                  master_limit,
  output logic                  irq
);
  import dlt_pkg::*;

  dlt_bus_e     bus_reg, bus_next;
  logic [31:0]  rdata_reg, rdata_next;
  dlt_cfg_s     cfg_reg, cfg_next;
  logic [26:0]  pw_reg, pw_next;
  logic [3:0][32:0] thr_reg, thr_next;
  logic [3:0]   ev_reg, ev_next;   // {lo2,hi2,lo1,hi1}
  logic [3:0]   mask_reg, mask_next;
  logic         ml_reg, ml_next;
  logic [14:0]  pre_reg, pre_next;
  logic [3:0][26:0] cnt_reg, cnt_next;
  logic [3:0]   prev_reg, prev_next;
  logic [3:0]   lines_reg, lines_next;
  logic         wr, rd, tick, preset;
  logic [1:0]   imm_clr, fail;
  logic [3:0]   ev_set, ev_clr, act;
  logic [7:0]   idx;

  // one wait cycle per access keeps read data registered
  assign wr = avs_req.write && bus_reg == BUS_ACK;
  assign rd = avs_req.read && bus_reg == BUS_ACK;
  assign avs_waitrequest = (avs_req.read || avs_req.write) &&
                           bus_reg == BUS_IDLE;
  assign avs_readdata = rdata_reg;
  assign preset  = wr && avs_req.address == OFS_CMD &&
                   avs_req.writedata[CMD_PRESET];
  assign imm_clr = (wr && avs_req.address == OFS_CMD) ?
                   avs_req.writedata[CMD_CLR2:CMD_CLR1] : 2'h0;
  assign idx  = avs_req.address - OFS_THR;
  assign fail = {ev_reg[3] | ev_reg[2], ev_reg[1] | ev_reg[0]};
  assign irq  = |(ev_reg & mask_reg);

  // bus handshake and read mux
  always_comb begin
    bus_next   = BUS_IDLE;
    rdata_next = rdata_reg;
    if (bus_reg == BUS_IDLE && (avs_req.read || avs_req.write)) begin
      bus_next   = BUS_ACK;
      rdata_next = 32'h0; // unmapped offsets read zero
      if (avs_req.read) begin
        case (avs_req.address)
          OFS_CTRL: rdata_next = {24'h0, cfg_reg};
          OFS_PW:   rdata_next = {5'h0, pw_reg};
          OFS_STAT: rdata_next = {28'h0, ev_reg};
          OFS_MASK: rdata_next = {28'h0, mask_reg};
          OFS_RES:  rdata_next = {28'h0, lines_reg[0], ml_reg, fail};
          default: begin
            if (avs_req.address >= OFS_THR && avs_req.address < OFS_STAT)
              rdata_next = idx[2] ? {31'h0, thr_reg[idx[4:3]][32]}
                                  : thr_reg[idx[4:3]][31:0];
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bus_reg   <= BUS_IDLE;
      rdata_reg <= 32'h0;
    end else begin
      bus_reg   <= bus_next;
      rdata_reg <= rdata_next;
    end
  end

  // configuration; bit value 1 enables, 0 disables
  always_comb begin
    cfg_next  = cfg_reg;
    pw_next   = pw_reg;
    thr_next  = thr_reg;
    mask_next = mask_reg;
    if (wr) begin
      case (avs_req.address)
        OFS_CTRL: cfg_next = avs_req.writedata[7:0];
        OFS_MASK: mask_next = avs_req.writedata[3:0];
        OFS_PW: begin
          // out-of-range widths load PW_MIN (zero or bits 31:27 set) or PW_MAX rather than fault
          if (avs_req.writedata[26:0] < PW_MIN ||
              |avs_req.writedata[31:27])
            pw_next = PW_MIN;
          else if (avs_req.writedata[26:0] > PW_MAX)
            pw_next = PW_MAX;
          else
            pw_next = avs_req.writedata[26:0];
        end
        default: begin
          if (avs_req.address >= OFS_THR && avs_req.address < OFS_STAT) begin
            if (idx[2])
              thr_next[idx[4:3]][32] = avs_req.writedata[0];
            else
              thr_next[idx[4:3]][31:0] = avs_req.writedata;
            // -2^32 lies outside the range, pull it in by one
            if (thr_next[idx[4:3]] == THR_BAD)
              thr_next[idx[4:3]] = THR_MIN;
          end
        end
      endcase
    end
    if (preset) begin
      cfg_next = CFG_RST;
      pw_next  = PW_RST;
      thr_next = THR_RST;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_reg  <= CFG_RST;
      pw_reg   <= PW_RST;
      thr_reg  <= THR_RST;
      mask_reg <= 4'h0;
    end else begin
      cfg_reg  <= cfg_next;
      pw_reg   <= pw_next;
      thr_reg  <= thr_next;
      mask_reg <= mask_next;
    end
  end

  // event flags; a new event wins over any clear in the same cycle
  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_test
      always_comb begin
        ev_set[2*t] = reading_valid && cfg_reg.test_en[t] &&
                      $signed(reading) > $signed(thr_reg[2*t]);
        ev_set[2*t+1] = reading_valid && cfg_reg.test_en[t] &&
                        $signed(reading) < $signed(thr_reg[2*t+1]);
        // auto-clear drops old events at each new tested reading
        ev_clr[2*t] = imm_clr[t] ||
                      (cfg_reg.auto_clr[t] && reading_valid &&
                       cfg_reg.test_en[t]) ||
                      (wr && avs_req.address == OFS_STAT &&
                       avs_req.writedata[2*t]);
        ev_clr[2*t+1] = imm_clr[t] ||
                        (cfg_reg.auto_clr[t] && reading_valid &&
                         cfg_reg.test_en[t]) ||
                        (wr && avs_req.address == OFS_STAT &&
                         avs_req.writedata[2*t+1]);
      end
    end
  endgenerate

  always_comb begin
    ev_next = ev_set | (ev_reg & ~ev_clr);
    // master_latch_enable master holds until a preset, even after both tests are cleared and pass
    ml_next = (cfg_reg.master_latch && ml_reg) || |ev_next;
    if (preset)
      ml_next = 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ev_reg <= 4'h0;
      ml_reg <= 1'b0;
    end else begin
      ev_reg <= ev_next;
      ml_reg <= ml_next;
    end
  end

  // ms prescaler shared by all lines: width is pw to pw+1 ms
  assign tick = pre_reg == 15'(TICK_CYC - 1);

  genvar l;
  generate
    for (l = 0; l < 4; l++) begin : g_line
      always_comb begin
        prev_next[l] = ev_reg[l];
        cnt_next[l]  = cnt_reg[l];
        // the extra ms covers a tick that lands right after the load
        if (ev_reg[l] && !prev_reg[l])
          cnt_next[l] = pw_reg + 27'h1;
        else if (tick && cnt_reg[l] != 27'h0)
          cnt_next[l] = cnt_reg[l] - 27'h1;
        act[l] = cfg_reg.pulse_en ? cnt_reg[l] != 27'h0 : ev_reg[l];
        lines_next[l] = (cfg_reg.outputs_en && act[l]) ^
                        cfg_reg.active_low;
      end
    end
  endgenerate

  always_comb begin
    pre_next = tick ? 15'h0 : pre_reg + 15'h1;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pre_reg   <= 15'h0;
      cnt_reg   <= '0;
      prev_reg  <= 4'h0;
      lines_reg <= 4'h0;
    end else begin
      pre_reg   <= pre_next;
      cnt_reg   <= cnt_next;
      prev_reg  <= prev_next;
      lines_reg <= lines_next;
    end
  end

  assign limit_lines  = lines_reg;
  assign master_limit = ml_reg;

  // checks
  sequence s_req_wait;
    (avs_req.read || avs_req.write) && avs_waitrequest;
  endsequence
  sequence s_done;
    !avs_waitrequest;
  endsequence

  chk_bus_answer: assert property (@(posedge mclk) disable iff (!resetn)
    s_req_wait |=> s_done) else $error("no answer after one wait");

  chk_reset_defaults: assert property (@(posedge mclk)
    $past(!resetn) |-> cfg_reg == CFG_RST && pw_reg == PW_RST &&
    thr_reg == THR_RST) else $error("defaults not loaded");

  chk_high_event: assert property (
    @(posedge mclk) disable iff (!resetn)
    reading_valid && cfg_reg.test_en[0] &&
    $signed(reading) > $signed(thr_reg[0]) |=> ev_reg[0])
    else $error("high event missed");

  chk_low_event: assert property (
    @(posedge mclk) disable iff (!resetn)
    reading_valid && cfg_reg.test_en[1] &&
    $signed(reading) < $signed(thr_reg[3]) |=> ev_reg[3])
    else $error("low event missed");

  chk_auto_clear: assert property (
    @(posedge mclk) disable iff (!resetn)
    reading_valid && cfg_reg.test_en[0] && cfg_reg.auto_clr[0] &&
    !ev_set[0] |=> !ev_reg[0])
    else $error("auto-clear kept event");

  chk_disabled_test: assert property (@(posedge mclk)
    disable iff (!resetn)
    !cfg_reg.test_en[1] && !$past(ev_reg[3]) && !ev_reg[3] |=> !ev_reg[3])
    else $error("disabled test raised event");

  chk_imm_clear: assert property (
    @(posedge mclk) disable iff (!resetn)
    imm_clr[0] && !ev_set[0] && !ev_set[1] |=>
    ev_reg[1:0] == 2'h0) else $error("clear left an event");

  chk_fail_flag: assert property (
    @(posedge mclk) disable iff (!resetn)
    avs_req.read && avs_req.address == OFS_RES && avs_waitrequest |=>
    avs_readdata[0] == $past(ev_reg[0] | ev_reg[1]))
    else $error("fail flag wrong");

  chk_pulse_width: assert property (
    @(posedge mclk) disable iff (!resetn)
    ev_reg[0] && !prev_reg[0] |=> cnt_reg[0] == $past(pw_reg) + 27'h1)
    else $error("pulse not loaded with width");

  chk_level_mode: assert property (
    @(posedge mclk) disable iff (!resetn)
    !cfg_reg.pulse_en && cfg_reg.outputs_en && !cfg_reg.active_low |=>
    limit_lines == $past(ev_reg)) else $error("level mode mismatch");

  chk_outputs_off: assert property (
    @(posedge mclk) disable iff (!resetn)
    !cfg_reg.outputs_en ##1 $stable(cfg_reg) |->
    limit_lines == {4{cfg_reg.active_low}}) else $error("lines not idle");

  chk_master_latch: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfg_reg.master_latch && ml_reg && !preset |=> ml_reg)
    else $error("master_latch_enable master dropped");
endmodule : dlt_top
`default_nettype wire
